/* File: shared/tdsi_pkg.sv */
// Package of the tone decoder status and interrupt block.
// Holds register addresses, status bit positions, mode codes and times.
// Assumes a 100 MHz device clock.
package tdsi_pkg;

  // Register addresses on the control bus.
  localparam logic [7:0] ADDR_ENTRY_INDEX = 8'h38;
  localparam logic [7:0] ADDR_STATUS      = 8'h3f;

  // Status register bit positions.
  localparam int ST_LIST_SEL  = 0;
  localparam int ST_UNLISTED  = 1;
  localparam int ST_TONE_DEC  = 2;
  localparam int ST_DEC_CHG   = 3;
  localparam int ST_LIST_FULL = 4;
  localparam int ST_TONE_CHG  = 5;

  // Widths and fill levels.
  localparam int IDX_W        = 5;
  localparam int PARAM_W      = 16;
  localparam int LIST_DEPTH   = 32;
  localparam int LOAD_CNT_W   = 6;
  localparam logic [LOAD_CNT_W-1:0] LOAD_FULL = 6'h20;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Decode mode field codes.
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_GROUP2 = 2'h1;
  localparam logic [1:0] MODE_GROUP1 = 2'h2;

  // Kinds of tone currently held by the decoder.
  localparam logic [1:0] KIND_SEL   = 2'h0;
  localparam logic [1:0] KIND_UNL   = 2'h1;
  localparam logic [1:0] KIND_OTHER = 2'h2;

  // Times and the cycle counts derived from them.
  localparam real CLK_FREQ_HZ        = 100.0e6;
  localparam real FAST_PERIOD_MS     = 4.3;
  localparam real SLOW_PERIOD_MS     = 8.6;
  localparam real SILENCE_TIMEOUT_MS = 100.0;
  localparam int  TIMER_W            = 24;
  localparam int  FAST_CYCLES    = $rtoi(FAST_PERIOD_MS * CLK_FREQ_HZ / 1000.0);
  localparam int  SLOW_CYCLES    = $rtoi(SLOW_PERIOD_MS * CLK_FREQ_HZ / 1000.0);
  localparam int  SILENCE_CYCLES =
    $rtoi(SILENCE_TIMEOUT_MS * CLK_FREQ_HZ / 1000.0);

  // Decoder states, one-hot.
  typedef enum logic [2:0] {
    TDSI_SILENT  = 3'h1,
    TDSI_PRESENT = 3'h2,
    TDSI_HOLD    = 3'h4
  } tdsi_state_type;

endpackage

/* File: src/tdsi_period_timer.sv */
// Free counter that pulses once every limit_i cycles while running.
// Assumes limit_i is at least one and changes only between periods.
`timescale 1ns/1ps
`default_nettype none
module tdsi_period_timer #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  // Control
  input  wire logic         run_i,
  input  wire logic         restart_i,
  input  wire logic [W-1:0] limit_i,
  // Result
  output logic              tick_o
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else if (restart_i || !run_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_r >= limit_i - W'(1)) begin
      cnt_r  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + W'(1);
      tick_o <= 1'b0;
    end
  end

endmodule // tdsi_period_timer
`default_nettype wire

/* File: src/tdsi_first_match.sv */
// Priority encoder that finds the lowest list position with a hit.
// Assumes hit_i already holds bandwidth and group qualification.
`timescale 1ns/1ps
`default_nettype none
module tdsi_first_match #(
  parameter int N  = 32,
  parameter int IW = 5
) (
  // Hits per list position
  input  wire logic [N-1:0]  hit_i,
  // Result
  output logic               found_o,
  output logic [IW-1:0]      index_o
);

  // Scanning downward lets the lowest position be written last and win.
  always_comb begin
    found_o = 1'b0;
    index_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (hit_i[i]) begin
        found_o = 1'b1;
        index_o = IW'(i);
      end
    end
  end

endmodule // tdsi_first_match
`default_nettype wire

/* File: src/tdsi_status_irq.sv */
// Decode state machine, matched entry index and status flags with the
// active-low interrupt of the paging tone decoder.
// Assumes the matching datapath delivers one result per measurement and
// that the host reads registers through a synchronous read strobe.
//
// Notes on behaviour
// - Entry index register shows the 5-bit matched position, upper bits zero.
// - Index zero is the first written position, 31 the last position.
// - Entry index and decoded parameters update in the same cycle.
// - Another selected-group listed tone while a tone is present sets the tone change bit.
// - List full sets once 32 entries are loaded into the selected list.
// - Zero power keeps list full; list wipe and global reset clear it.
// - Decode change bit sets on silence timeout, on a new selected-group match or on any other tone.
// - Tone decode bit is one in the tone present and hold states.
// - Selected-group listed tone from silence enters tone present with interrupt.
// - Unlisted tone from silence enters tone present, unknown set, no interrupt.
// - Other-group listed tone from silence stays silent, no interrupt.
// - Any other tone while tone present keeps decode bit and interrupts.
// - Tone loss runs a fixed timer; expiry returns the decoder to silence.
// - Unknown flag sets on unlisted decode and clears on listed decode.
// - List select bit tells which list was selected at match time.
// - Interrupt low when bit 3 or 5 set or bit 4 rises.
// - Reading status releases the interrupt and clears bits 3 and 5.
// - Bits 2 to 0 refresh each measurement period from interrupt assertion.
// - Zero power forces status to 000x0000, list full kept.
// - Decode mode off clears status bits 0, 1, 2, 3 and 5.
// - Mode 00 off and silent, 01 group two, 10 group one, 11 forbidden.
// - Matching takes the lowest hit position and reports its parameters.
`timescale 1ns/1ps
`default_nettype none
module tdsi_status_irq #(
  parameter int N               = tdsi_pkg::LIST_DEPTH,
  parameter int FAST_PERIOD_CYC = tdsi_pkg::FAST_CYCLES,
  parameter int SLOW_PERIOD_CYC = tdsi_pkg::SLOW_CYCLES,
  parameter int SILENCE_CYC     = tdsi_pkg::SILENCE_CYCLES
) (
  // Clock and reset
  input  wire logic                          ref_clk_i,
  input  wire logic                          rstn_i,
  // Control settings held by the host
  input  wire logic [1:0]                    decode_mode_i,
  input  wire logic                          fast_mode_i,
  input  wire logic                          zero_power_i,
  input  wire logic                          list_select_i,
  // Commands, one-cycle pulses
  input  wire logic                          global_reset_i,
  input  wire logic                          list_wipe_i,
  input  wire logic                          list_load_i,
  // Measurement results from the matching datapath
  input  wire logic                          meas_stb_i,
  input  wire logic                          tone_seen_i,
  input  wire logic [N-1:0]                  entry_hit_i,
  input  wire logic [N-1:0]                  entry_grp1_i,
  input  wire logic [N-1:0]                  entry_grp2_i,
  input  wire logic [N*tdsi_pkg::PARAM_W-1:0] entry_params_i,
  // Register read port
  input  wire logic                          rd_stb_i,
  input  wire logic [7:0]                    rd_addr_i,
  output logic      [7:0]                    rd_data_o,
  // Results
  output logic [tdsi_pkg::PARAM_W-1:0]       decoded_params_o,
  output logic                               interrupt_request_low_o
);
  import tdsi_pkg::*;

  tdsi_state_type     state_r;
  logic [IDX_W-1:0]   idx_r;
  logic [1:0]         kind_r;
  logic               unl_r;
  logic               list_r;
  logic               tone_chg_r;
  logic               full_r;
  logic               full_pend_r;
  logic               dec_chg_r;
  logic               vis_dec_r;
  logic               vis_unl_r;
  logic               vis_list_r;
  logic [LOAD_CNT_W-1:0] load_cnt_r [2];
  logic [7:0]         status_w;

  // Group qualification follows the decode mode encoding.
  function automatic logic [N-1:0] group_mask(input logic [1:0] mode,
                                              input logic [N-1:0] g1,
                                              input logic [N-1:0] g2);
    if (mode == MODE_GROUP1) begin
      return g1;
    end else if (mode == MODE_GROUP2) begin
      return g2;
    end else begin
      return '0;
    end
  endfunction

  logic [N-1:0]     sel_hit;
  logic             sel_found;
  logic [IDX_W-1:0] first_idx;
  logic             listed_any;
  logic             mode_on;
  logic             meas;
  logic             in_dec;
  logic [1:0]       new_kind;
  logic             differs;
  logic             ev_enter_sel;
  logic             ev_enter_unl;
  logic             ev_other;
  logic             ev_lost;
  logic             list_upd;
  logic             status_rd;
  logic             sil_tick;
  logic             per_tick;
  logic             irq_low_nxt;
  logic             irq_fall;
  logic             full_rise;
  logic [TIMER_W-1:0] per_limit;
  logic             unl_nxt;
  logic             dec_nxt;

  assign sel_hit    = entry_hit_i & group_mask(decode_mode_i, entry_grp1_i,
                                               entry_grp2_i);
  assign listed_any = |entry_hit_i;
  assign mode_on    = (decode_mode_i != MODE_OFF) && !zero_power_i;
  assign meas       = meas_stb_i && tone_seen_i && mode_on;
  assign in_dec     = (state_r == TDSI_PRESENT) || (state_r == TDSI_HOLD);
  assign status_rd  = rd_stb_i && (rd_addr_i == ADDR_STATUS);

  tdsi_first_match #(
    .N  (N),
    .IW (IDX_W)
  ) u_first_match (
    .hit_i   (sel_hit),
    .found_o (sel_found),
    .index_o (first_idx)
  );

  always_comb begin
    if (sel_found) begin
      new_kind = KIND_SEL;
    end else if (listed_any) begin
      new_kind = KIND_OTHER;
    end else begin
      new_kind = KIND_UNL;
    end
  end

  assign differs = (new_kind != kind_r) ||
                   ((new_kind == KIND_SEL) && (first_idx != idx_r));
  assign ev_enter_sel = (state_r == TDSI_SILENT) && meas && sel_found;
  assign ev_enter_unl = (state_r == TDSI_SILENT) && meas && !listed_any;
  assign ev_other     = in_dec && meas && differs;
  assign ev_lost      = (state_r == TDSI_HOLD) && sil_tick;
  assign list_upd     = ev_enter_sel || (ev_other && sel_found);

  // Decode state machine.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= TDSI_SILENT;
      kind_r  <= KIND_UNL;
    end else if (!mode_on || global_reset_i) begin
      state_r <= TDSI_SILENT;
      kind_r  <= KIND_UNL;
    end else begin
      case (state_r)
        TDSI_SILENT: begin
          if (ev_enter_sel || ev_enter_unl) begin
            state_r <= TDSI_PRESENT;
            kind_r  <= new_kind;
          end
        end
        TDSI_PRESENT: begin
          if (meas) begin
            kind_r <= new_kind;
          end else if (meas_stb_i && !tone_seen_i) begin
            state_r <= TDSI_HOLD;
          end
        end
        TDSI_HOLD: begin
          if (meas) begin
            state_r <= TDSI_PRESENT;
            kind_r  <= new_kind;
          end else if (sil_tick) begin
            state_r <= TDSI_SILENT;
          end
        end
        default: begin
          state_r <= TDSI_SILENT;
        end
      endcase
    end
  end

  // Silence timeout runs only while the tone is missing.
  tdsi_period_timer #(
    .W (TIMER_W)
  ) u_silence_timer (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .run_i     (state_r == TDSI_HOLD),
    .restart_i (meas),
    .limit_i   (TIMER_W'(SILENCE_CYC)),
    .tick_o    (sil_tick)
  );

  // Matched entry and its parameters, loaded together.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idx_r            <= '0;
      decoded_params_o <= '0;
      list_r           <= 1'b0;
    end else if (global_reset_i) begin
      idx_r            <= '0;
      decoded_params_o <= '0;
      list_r           <= 1'b0;
    end else if (list_upd) begin
      idx_r            <= first_idx;
      decoded_params_o <= entry_params_i[first_idx*PARAM_W +: PARAM_W];
      list_r           <= list_select_i;
    end
  end

  // Next decoder view, so a refresh taken with an event is not stale.
  always_comb begin
    if (ev_enter_unl || (ev_other && !listed_any)) begin
      unl_nxt = 1'b1;
    end else if (meas && listed_any) begin
      unl_nxt = 1'b0;
    end else begin
      unl_nxt = unl_r;
    end
  end

  assign dec_nxt = (in_dec && !ev_lost) || ev_enter_sel || ev_enter_unl;

  // Unknown-tone flag of the decoder itself.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      unl_r <= 1'b0;
    end else if (!mode_on || global_reset_i) begin
      unl_r <= 1'b0;
    end else begin
      unl_r <= unl_nxt;
    end
  end

  // Event flags; a new event wins over the clearing read.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dec_chg_r  <= 1'b0;
      tone_chg_r <= 1'b0;
    end else if (!mode_on || global_reset_i) begin
      dec_chg_r  <= 1'b0;
      tone_chg_r <= 1'b0;
    end else begin
      if (ev_enter_sel || ev_other || ev_lost) begin
        dec_chg_r <= 1'b1;
      end else if (status_rd) begin
        dec_chg_r <= 1'b0;
      end
      if (ev_other && sel_found) begin
        tone_chg_r <= 1'b1;
      end else if (status_rd) begin
        tone_chg_r <= 1'b0;
      end
    end
  end

  // Load counting per list; zero power leaves it alone.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      load_cnt_r[0] <= '0;
      load_cnt_r[1] <= '0;
      full_r        <= 1'b0;
    end else if (global_reset_i) begin
      load_cnt_r[0] <= '0;
      load_cnt_r[1] <= '0;
      full_r        <= 1'b0;
    end else if (list_wipe_i) begin
      load_cnt_r[list_select_i] <= '0;
      full_r                    <= 1'b0;
    end else if (list_load_i) begin
      if (load_cnt_r[list_select_i] != LOAD_FULL) begin
        load_cnt_r[list_select_i] <= load_cnt_r[list_select_i] +
                                     LOAD_CNT_W'(1);
      end
      if (load_cnt_r[list_select_i] >= LOAD_FULL - LOAD_CNT_W'(1)) begin
        full_r <= 1'b1;
      end
    end
  end

  assign full_rise = list_load_i && !global_reset_i && !list_wipe_i &&
                     !full_r &&
                     (load_cnt_r[list_select_i] >= LOAD_FULL - LOAD_CNT_W'(1));

  // A list-full rise only pulses, so it is held until the status read.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      full_pend_r <= 1'b0;
    end else if (full_rise) begin
      full_pend_r <= 1'b1;
    end else if (status_rd || global_reset_i) begin
      full_pend_r <= 1'b0;
    end
  end

  // Interrupt follows the next values of the flags it depends on.
  always_comb begin
    irq_low_nxt = full_rise || (full_pend_r && !status_rd);
    if (mode_on && !global_reset_i) begin
      irq_low_nxt = irq_low_nxt || ev_enter_sel || ev_other || ev_lost ||
                    (dec_chg_r && !status_rd) ||
                    (tone_chg_r && !status_rd);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      interrupt_request_low_o <= 1'b1;
    end else begin
      interrupt_request_low_o <= !irq_low_nxt;
    end
  end

  assign irq_fall  = irq_low_nxt && interrupt_request_low_o;
  assign per_limit = fast_mode_i ? TIMER_W'(FAST_PERIOD_CYC)
                                 : TIMER_W'(SLOW_PERIOD_CYC);

  tdsi_period_timer #(
    .W (TIMER_W)
  ) u_period_timer (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .run_i     (mode_on),
    .restart_i (irq_fall),
    .limit_i   (per_limit),
    .tick_o    (per_tick)
  );

  // Visible decode bits: refreshed on each period and with each interrupt.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vis_dec_r  <= 1'b0;
      vis_unl_r  <= 1'b0;
      vis_list_r <= 1'b0;
    end else if (!mode_on || global_reset_i) begin
      vis_dec_r  <= 1'b0;
      vis_unl_r  <= 1'b0;
      vis_list_r <= 1'b0;
    end else if (per_tick || irq_fall) begin
      vis_dec_r  <= dec_nxt;
      vis_unl_r  <= unl_nxt;
      // The list bit reads zero unless a listed match is being reported.
      vis_list_r <= dec_nxt && !unl_nxt &&
                    (list_upd ? list_select_i : list_r);
    end
  end

  assign status_w = {2'b00, tone_chg_r, full_r, dec_chg_r,
                     vis_dec_r, vis_unl_r, vis_list_r};

  // Read port; there is no write path, so no write can disturb state.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= BYTE_ZERO;
    end else if (!rd_stb_i) begin
      rd_data_o <= rd_data_o;
    end else if (rd_addr_i == ADDR_ENTRY_INDEX) begin
      rd_data_o <= {3'b000, idx_r};
    end else if (rd_addr_i == ADDR_STATUS) begin
      rd_data_o <= status_w;
    end else begin
      rd_data_o <= BYTE_ZERO;
    end
  end

  idx_read_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    rd_stb_i && rd_addr_i == ADDR_ENTRY_INDEX |=>
      rd_data_o[7:5] == 3'b000 && rd_data_o[4:0] == $past(idx_r))
    else $error("entry index read is wrong");
  idx_params_sync_a: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    $changed(idx_r) && !$past(global_reset_i) |->
      $past(list_upd) && idx_r == $past(first_idx))
    else $error("index changed without a match update");
  tone_change_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ev_other && sel_found && mode_on && !global_reset_i |=>
      tone_chg_r && !interrupt_request_low_o)
    else $error("tone change flag or interrupt missing");
  full_set_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    full_rise |=> full_r && !interrupt_request_low_o)
    else $error("list full not flagged");
  unlisted_quiet_a: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    ev_enter_unl && !dec_chg_r && !tone_chg_r && !full_pend_r &&
      !full_rise && !global_reset_i |=>
      interrupt_request_low_o && state_r == TDSI_PRESENT && unl_r)
    else $error("unlisted tone raised interrupt");
  irq_level_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    dec_chg_r || tone_chg_r |-> !interrupt_request_low_o)
    else $error("interrupt not low with flag set");
  read_release_a: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    status_rd && !irq_low_nxt |=>
      interrupt_request_low_o && !dec_chg_r && !tone_chg_r)
    else $error("status read did not release interrupt");
  mode_off_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    decode_mode_i == MODE_OFF |=>
      (status_w & 8'h2f) == 8'h00 && state_r == TDSI_SILENT)
    else $error("mode off did not clear status");
  zero_power_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    zero_power_i && !full_rise && !list_wipe_i && !global_reset_i |=>
      (status_w & 8'hef) == 8'h00 && full_r == $past(full_r))
    else $error("zero power status pattern wrong");
  silence_end_a: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    ev_lost && mode_on && !global_reset_i |=>
      state_r == TDSI_SILENT && dec_chg_r)
    else $error("silence timeout did not return to silence");

endmodule // tdsi_status_irq
`default_nettype wire

/* File: testbench/tdsi_host_model.sv */
// Host side model of the decoder: register reads and the decode mode field.
// Assumes the device samples rd_stb_i and rd_addr_i on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module tdsi_host_model (
  // Clock
  input  wire logic       ref_clk_i,
  // Register read port
  input  wire logic [7:0] rd_data_i,
  output logic            rd_stb_o,
  output logic      [7:0] rd_addr_o,
  // Decode mode field
  output logic      [1:0] decode_mode_o
);
  initial begin
    rd_stb_o      = 1'b0;
    rd_addr_o     = 8'h00;
    decode_mode_o = 2'h0;
  end

  // The address is inverted after the strobe so a stale value cannot pass.
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge ref_clk_i);
    #1;
    rd_stb_o  = 1'b1;
    rd_addr_o = addr;
    @(posedge ref_clk_i);
    #1;
    rd_stb_o  = 1'b0;
    rd_addr_o = ~addr;
    data      = rd_data_i;
  endtask

  // The illegal code 11 is never offered; it falls back to off.
  task automatic set_mode(input logic [1:0] mode);
    @(posedge ref_clk_i);
    #1;
    decode_mode_o = (mode == 2'h3) ? 2'h0 : mode;
  endtask

  // Both mode bits low for 12 us clears the decode history.
  task automatic flush(input logic [1:0] mode);
    set_mode(2'h0);
    repeat (1200) @(posedge ref_clk_i);
    set_mode(mode);
  endtask
endmodule // tdsi_host_model
`default_nettype wire

/* File: testbench/tone_decode_status_irq_test.sv */
// Self-checking bench of the status and interrupt block.
// Assumes short periods: fast 20, slow 40, silence timeout 30 cycles.
`timescale 1ns/1ps
`default_nettype none
module tone_decode_status_irq_test;
  import tdsi_pkg::*;
  localparam int SIL = 30;
  logic       ref_clk_i, rstn_i, fast_mode_i, zero_power_i, list_select_i;
  logic       global_reset_i, list_wipe_i, list_load_i, meas_stb_i;
  logic       tone_seen_i, rd_stb_i, interrupt_request_low_o;
  logic [31:0] entry_hit_i, entry_grp1_i, entry_grp2_i;
  logic [LIST_DEPTH*PARAM_W-1:0] entry_params_i;
  logic [7:0] rd_addr_i, rd_data_o, rd;
  logic [1:0] decode_mode_i;
  logic [PARAM_W-1:0] decoded_params_o;
  int         fail_count, samples_checked, cycles;

  tdsi_status_irq #(.N(32), .FAST_PERIOD_CYC(20), .SLOW_PERIOD_CYC(40),
    .SILENCE_CYC(SIL)) u_tdsi_status_irq (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .decode_mode_i(decode_mode_i),
    .fast_mode_i(fast_mode_i), .zero_power_i(zero_power_i),
    .list_select_i(list_select_i), .global_reset_i(global_reset_i),
    .list_wipe_i(list_wipe_i), .list_load_i(list_load_i),
    .meas_stb_i(meas_stb_i), .tone_seen_i(tone_seen_i),
    .entry_hit_i(entry_hit_i), .entry_grp1_i(entry_grp1_i),
    .entry_grp2_i(entry_grp2_i), .entry_params_i(entry_params_i),
    .rd_stb_i(rd_stb_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
    .decoded_params_o(decoded_params_o),
    .interrupt_request_low_o(interrupt_request_low_o));

  tdsi_host_model u_tdsi_host_model (
    .ref_clk_i(ref_clk_i), .rd_data_i(rd_data_o), .rd_stb_o(rd_stb_i),
    .rd_addr_o(rd_addr_i), .decode_mode_o(decode_mode_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic results();
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // A hang costs one mismatch and ends the run at the report.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      results();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] exp);
    u_tdsi_host_model.read_reg(a, rd);
    check({8'h00, rd & m}, {8'h00, exp});
  endtask

  task automatic meas(input logic tone, input logic [31:0] hit);
    @(posedge ref_clk_i);
    #1;
    meas_stb_i  = 1'b1;
    tone_seen_i = tone;
    entry_hit_i = hit;
    @(posedge ref_clk_i);
    #1;
    meas_stb_i  = 1'b0;
    tone_seen_i = ~tone;
    entry_hit_i = ~hit;
  endtask

  task automatic cmd(input logic [2:0] c, input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      #1;
      {global_reset_i, list_wipe_i, list_load_i} = c;
      @(posedge ref_clk_i);
      #1;
      {global_reset_i, list_wipe_i, list_load_i} = 3'b000;
    end
  endtask

  initial begin
    {fail_count, samples_checked, cycles} = '0;
    {rstn_i, zero_power_i, global_reset_i, list_wipe_i, list_load_i} = '0;
    {meas_stb_i, tone_seen_i, entry_hit_i} = '0;
    fast_mode_i   = 1'b1;
    list_select_i = 1'b1;
    entry_grp1_i  = 32'h8000_0088;
    entry_grp2_i  = 32'h0000_0020;
    for (int i = 0; i < 32; i++) entry_params_i[16*i +: 16] = 16'h1000 + i;
    repeat (16) @(posedge ref_clk_i);
    #1;
    rstn_i = 1'b1;
    check(interrupt_request_low_o, 1'b1);
    rdchk(ADDR_STATUS, 8'hff, 8'h00);
    rdchk(8'h3c, 8'hff, 8'h00);
    meas(1'b1, 32'h0000_0088);
    check(interrupt_request_low_o, 1'b1);
    u_tdsi_host_model.set_mode(MODE_GROUP1);
    meas(1'b1, 32'h0000_0088);
    check(decoded_params_o, 16'h1003);
    check(interrupt_request_low_o, 1'b0);
    rdchk(ADDR_ENTRY_INDEX, 8'hff, 8'h03);
    rdchk(ADDR_STATUS, 8'hff, 8'h0d);
    check(interrupt_request_low_o, 1'b1);
    rdchk(ADDR_STATUS, 8'hff, 8'h05);
    meas(1'b1, 32'h8000_0000);
    check(decoded_params_o, 16'h101f);
    check(interrupt_request_low_o, 1'b0);
    rdchk(ADDR_ENTRY_INDEX, 8'hff, 8'h1f);
    rdchk(ADDR_STATUS, 8'hff, 8'h2d);
    meas(1'b1, 32'h0);
    check(interrupt_request_low_o, 1'b0);
    rdchk(ADDR_STATUS, 8'hff, 8'h0e);
    meas(1'b0, 32'h0);
    repeat (SIL + 10) @(posedge ref_clk_i);
    #1;
    check(interrupt_request_low_o, 1'b0);
    rdchk(ADDR_STATUS, 8'h0c, 8'h08);
    fast_mode_i = 1'b0;
    u_tdsi_host_model.flush(MODE_GROUP1);
    meas(1'b1, 32'h0000_0020);
    check(interrupt_request_low_o, 1'b1);
    rdchk(ADDR_STATUS, 8'hff, 8'h00);
    meas(1'b1, 32'h0);
    check(interrupt_request_low_o, 1'b1);
    repeat (21) @(posedge ref_clk_i);
    rdchk(ADDR_STATUS, 8'hff, 8'h00);
    repeat (20) @(posedge ref_clk_i);
    rdchk(ADDR_STATUS, 8'hff, 8'h06);
    u_tdsi_host_model.set_mode(MODE_OFF);
    rdchk(ADDR_STATUS, 8'h2f, 8'h00);
    u_tdsi_host_model.set_mode(MODE_GROUP2);
    meas(1'b1, 32'h0000_0020);
    check(interrupt_request_low_o, 1'b0);
    rdchk(ADDR_ENTRY_INDEX, 8'hff, 8'h05);
    rdchk(ADDR_STATUS, 8'hff, 8'h0d);
    u_tdsi_host_model.set_mode(MODE_OFF);
    cmd(3'b001, 31);
    repeat (2) @(posedge ref_clk_i);
    #1;
    check(interrupt_request_low_o, 1'b1);
    cmd(3'b001, 1);
    repeat (2) @(posedge ref_clk_i);
    #1;
    check(interrupt_request_low_o, 1'b0);
    zero_power_i = 1'b1;
    rdchk(ADDR_STATUS, 8'hff, 8'h10);
    check(interrupt_request_low_o, 1'b1);
    zero_power_i = 1'b0;
    cmd(3'b010, 1);
    rdchk(ADDR_STATUS, 8'h10, 8'h00);
    cmd(3'b001, 32);
    rdchk(ADDR_STATUS, 8'h10, 8'h10);
    cmd(3'b100, 1);
    rdchk(ADDR_STATUS, 8'h10, 8'h00);
    results();
  end
endmodule // tone_decode_status_irq_test
`default_nettype wire
